/* File: hdl/third_harmonic_uv_element.sv */
// Definite-time third harmonic undervoltage element with start and trip outputs.
//
// Contract
// - Start is active while the measured magnitude is below the pick-up threshold.
// - Trip only after the full set delay has elapsed since start.
// - Block input holds start and trip inactive.
// - Operation setting off gives no start and no trip; on by default.
// - Start-only mode suppresses trip, start still given; off by default.
// - Delay settable 0 to 60000 ms in 1 ms steps, default 100 ms.
// - Delay counts only while the magnitude stays below the threshold.
// - Operating time equals the set delay regardless of how low the magnitude is.
// - Decision stage forms trip from started and expired status.
// - Characteristic stage gives started and delay-expired status signals.
`timescale 1ns/100ps
`default_nettype none
module third_harmonic_uv_element
	import thuvg_pkg::*;
#(
	parameter int CYC_PER_MS = THUVG_CYC_PER_MS
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [6:0]  i_neutral_third_harmonic_magnitude,
	input  wire logic        i_harmonic_uv_block_in,
	input  wire thuvg_cfg_t  i_cfg,
	output logic             o_harmonic_uv_start_out,
	output logic             o_harmonic_uv_trip_out,
	output thuvg_stat_t      o_status
);
	logic        blk_meta;
	logic        blk_sync;
	logic        below;
	logic        active;
	logic        ms_tick;
	logic        run_ms;
	logic [15:0] delay_clamped;
	logic [15:0] ms_cnt;
	logic [15:0] next_ms_cnt;
	thuvg_stat_t stat;
	thuvg_stat_t next_stat;
	logic        start_q;
	logic        trip_q;
	logic        next_start;
	logic        next_trip;

	// The block input is a binary input from outside, so it is synchronised first.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			blk_meta <= 1'b0;
			blk_sync <= 1'b0;
		end else begin
			blk_meta <= i_harmonic_uv_block_in;
			blk_sync <= blk_meta;
		end
	end

	// Out-of-range delay settings saturate at the largest permitted value.
	assign delay_clamped = (i_cfg.delay_ms > THUVG_DELAY_MAX) ? THUVG_DELAY_MAX : i_cfg.delay_ms;
	assign below  = i_neutral_third_harmonic_magnitude < i_cfg.pickup_threshold_value;
	assign active = below && i_cfg.enabled && !blk_sync;

	// The millisecond divider starts with the started status, so that the trip comes a full
	// set delay after the start output and never one cycle short of it.
	assign run_ms = active && stat.started;

	thuvg_ms_tick #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_tick (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_run     (run_ms),
		.o_tick    (ms_tick)
	);

	// Characteristic stage: the magnitude only gates the count, never its rate.
	always_comb begin
		next_ms_cnt = ms_cnt;
		next_stat.started = active;
		next_stat.expired = 1'b0;
		if (!active) begin
			next_ms_cnt = 16'h0000;
		end else begin
			if (ms_tick && ms_cnt < delay_clamped) begin
				next_ms_cnt = ms_cnt + 16'h0001;
			end
			next_stat.expired = (next_ms_cnt >= delay_clamped);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ms_cnt <= 16'h0000;
			stat   <= '0;
		end else begin
			ms_cnt <= next_ms_cnt;
			stat   <= next_stat;
		end
	end

	// Decision stage: trip from started and expired unless start-only mode holds.
	always_comb begin
		next_start = stat.started && active;
		next_trip  = stat.started && stat.expired && active && !i_cfg.start_only;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			start_q <= 1'b0;
			trip_q  <= 1'b0;
		end else begin
			start_q <= next_start;
			trip_q  <= next_trip;
		end
	end

	assign o_harmonic_uv_start_out = start_q;
	assign o_harmonic_uv_trip_out  = trip_q;
	assign o_status                = stat;

	// Helper for the checks: cycles the element has been continuously active.
	// It is 40 bits wide so that the longest delay at the full clock rate still fits.
	logic [39:0] act_cyc;
	logic [39:0] next_act_cyc;
	always_comb begin
		next_act_cyc = act_cyc;
		if (!active) begin
			next_act_cyc = 40'h00_0000_0000;
		end else if (act_cyc != 40'hFF_FFFF_FFFF) begin
			next_act_cyc = act_cyc + 40'h00_0000_0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			act_cyc <= 40'h00_0000_0000;
		end else begin
			act_cyc <= next_act_cyc;
		end
	end

	sequence s_inactive;
		!active;
	endsequence

	sequence s_outputs_low;
		!o_harmonic_uv_start_out && !o_harmonic_uv_trip_out;
	endsequence

	sequence s_delay_done;
		active && !i_cfg.start_only
			&& act_cyc == 40'(delay_clamped) * 40'(CYC_PER_MS) + 40'h00_0000_0001;
	endsequence

	a_trip_not_early: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_harmonic_uv_trip_out |-> act_cyc >= 40'(delay_clamped) * 40'(CYC_PER_MS) + 40'h00_0000_0002)
		else $error("Trip asserted before the set delay elapsed.");
	a_block_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		blk_sync |=> s_outputs_low)
		else $error("Block input did not clear outputs.");
	a_off_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_cfg.enabled |=> !o_harmonic_uv_start_out)
		else $error("Disabled element gave a start.");
	a_start_only_trip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_cfg.start_only |=> !o_harmonic_uv_trip_out)
		else $error("Trip given in start-only mode.");
	a_start_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		active [*2] |=> o_harmonic_uv_start_out)
		else $error("Start missing while below threshold.");
	a_count_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!active |=> ms_cnt == 16'h0000)
		else $error("Delay count not cleared when above threshold.");
	a_clear_at_once: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_inactive |=> s_outputs_low)
		else $error("Outputs not cleared at once.");
	a_trip_needs_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_harmonic_uv_trip_out |-> o_harmonic_uv_start_out && $past(stat.expired))
		else $error("Trip without started and expired status.");
	a_zero_delay_trip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(delay_clamped == 16'h0000 && !i_cfg.start_only && active) [*3]
		|-> o_harmonic_uv_trip_out)
		else $error("Zero delay did not trip promptly.");
	a_trip_in_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_delay_done |=> o_harmonic_uv_trip_out)
		else $error("Trip missing once the set delay elapsed.");
	a_start_needs_below: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_harmonic_uv_start_out |-> $past(below))
		else $error("Start given without the magnitude below the threshold.");
endmodule
`default_nettype wire

/* File: pkg/thuvg_pkg.sv */
// Package with constants and carrier types for the third harmonic undervoltage element.
`default_nettype none
package thuvg_pkg;
	localparam int THUVG_CLK_MHZ            = 250;
	localparam int THUVG_MS_NS              = 1000000;
	localparam int THUVG_CLK_PERIOD_NS      = 4;
	localparam int THUVG_CYC_PER_MS         = THUVG_MS_NS / THUVG_CLK_PERIOD_NS;
	localparam int THUVG_PCT_W              = 7;
	localparam int THUVG_DLY_W              = 16;
	localparam logic [6:0]  THUVG_PICKUP_RST = 7'h1E;
	localparam logic [6:0]  THUVG_PICKUP_MIN = 7'h02;
	localparam logic [6:0]  THUVG_PICKUP_MAX = 7'h3C;
	localparam logic [15:0] THUVG_DELAY_RST  = 16'h0064;
	localparam logic [15:0] THUVG_DELAY_MAX  = 16'hEA60;
	localparam logic        THUVG_OPER_RST   = 1'b1;
	localparam logic        THUVG_SONLY_RST  = 1'b0;

	typedef struct packed {
		logic        enabled;
		logic        start_only;
		logic [6:0]  pickup_threshold_value;
		logic [15:0] delay_ms;
	} thuvg_cfg_t;

	typedef struct packed {
		logic started;
		logic expired;
	} thuvg_stat_t;
endpackage
`default_nettype wire

/* File: hdl/thuvg_ms_tick.sv */
// Millisecond enable divider for the delay counter.
`timescale 1ns/100ps
`default_nettype none
module thuvg_ms_tick
	import thuvg_pkg::*;
#(
	parameter int CYC_PER_MS = THUVG_CYC_PER_MS
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_run,
	output logic      o_tick
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;

	// The divider restarts with each start so that the first millisecond is a full one.
	always_comb begin
		next_cnt = cnt;
		if (!i_run || cnt == 32'(CYC_PER_MS - 1)) begin
			next_cnt = 32'h0000_0000;
		end else begin
			next_cnt = cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt <= 32'h0000_0000;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign o_tick = i_run && (cnt == 32'(CYC_PER_MS - 1));
endmodule
`default_nettype wire

/* File: tb/thuvg_upstream_model.sv */
// Model of the harmonic stage and binary input that feed the element.
`timescale 1ns/100ps
`default_nettype none
module thuvg_upstream_model (
	input  wire logic [6:0] i_level,
	input  wire logic       i_block_req,
	output logic [6:0]      o_magnitude,
	output logic            o_block
);
	// The magnitude is handed over as already computed upstream.
	assign o_magnitude = i_level;
	assign o_block     = i_block_req;
endmodule
`default_nettype wire

/* File: tb/test_third_harmonic_uv_element.sv */
// Testbench for the third harmonic undervoltage element.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module test_third_harmonic_uv_element;
	import thuvg_pkg::*;
	logic        i_clk;
	logic        i_sys_rst;
	logic [6:0]  level;
	logic        blk;
	logic [6:0]  mag;
	logic        blk_pin;
	thuvg_cfg_t  cfg;
	logic        start;
	logic        trip;
	thuvg_stat_t stat;
	int          n_errors;
	int          checked;
	thuvg_upstream_model i_thuvg_upstream_model (.i_level(level), .i_block_req(blk),
		.o_magnitude(mag), .o_block(blk_pin));
	third_harmonic_uv_element #(.CYC_PER_MS(4)) i_third_harmonic_uv_element (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_neutral_third_harmonic_magnitude(mag),
		.i_harmonic_uv_block_in(blk_pin), .i_cfg(cfg), .o_harmonic_uv_start_out(start),
		.o_harmonic_uv_trip_out(trip), .o_status(stat));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic drop(input logic [6:0] m);
		@(posedge i_clk);
		level <= m;
		#1;
	endtask
	task automatic fin(input string s);
		drop(7'h3F);
		cyc(1);
		`CHK("start idle", 1'b0, start)
		`CHK("trip idle", 1'b0, trip)
		`CHK("expired idle", 1'b0, stat.expired)
		$display("Test %s done", s);
	endtask
	// Delay in ms becomes four cycles each, so the trip edge is exact.
	task automatic trip_run(input logic [6:0] m, input logic [15:0] d, input logic so,
		input logic exp);
		@(posedge i_clk);
		cfg.delay_ms   <= d;
		cfg.start_only <= so;
		level          <= m;
		#1;
		cyc(2);
		`CHK("start", 1'b1, start)
		`CHK("started", 1'b1, stat.started)
		if (d > 16'h0000) begin
			cyc(4 * d - 1);
			`CHK("trip early", 1'b0, trip)
			cyc(1);
		end
		`CHK("trip", exp, trip)
		`CHK("expired", 1'b1, stat.expired)
		fin("delay");
	endtask
	task automatic quiet(input string s);
		@(posedge i_clk);
		cfg.delay_ms <= 16'h0000;
		level        <= 7'h05;
		#1;
		cyc(4);
		`CHK(s, 1'b0, start)
		`CHK("quiet trip", 1'b0, trip)
		`CHK("quiet status", 1'b0, stat.started)
		fin(s);
	endtask
	task automatic test_done;
		$display("Checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		test_done;
	end
	initial begin
		n_errors  = 0;
		checked   = 0;
		level     = 7'h3F;
		blk       = 1'b0;
		cfg       = '{1'b1, 1'b0, THUVG_PICKUP_RST, 16'h0002};
		i_sys_rst = 1'b1;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1;
		`CHK("reset trip", 1'b0, trip)
		`CHK("reset start", 1'b0, start)
		trip_run(7'h1D, 16'h0002, 1'b0, 1'b1);
		trip_run(7'h00, 16'h0002, 1'b0, 1'b1);
		trip_run(7'h1D, 16'h0002, 1'b1, 1'b0);
		trip_run(7'h0A, 16'h0000, 1'b0, 1'b1);
		@(posedge i_clk);
		cfg.delay_ms <= 16'h0003;
		level        <= 7'h14;
		#1;
		cyc(6);
		`CHK("partial trip", 1'b0, trip)
		drop(7'h3F);
		trip_run(7'h14, 16'h0003, 1'b0, 1'b1);
		drop(THUVG_PICKUP_RST);
		cyc(4);
		`CHK("equal", 1'b0, start)
		fin("equal");
		@(posedge i_clk);
		blk <= 1'b1;
		cyc(2);
		quiet("block");
		@(posedge i_clk);
		blk         <= 1'b0;
		cfg.enabled <= 1'b0;
		#1;
		quiet("off");
		test_done;
	end
endmodule
`default_nettype wire
